/* File: rtl/npc_top.sv */
// npc_top: program-memory and erasable-memory programming control
// assumes: cpu register port on clock_i, mode pins asynchronous
`timescale 1ns/100ps
`default_nettype none
module npc_top (
    // clock and reset
    input wire logic clock_i,
    input wire logic sys_rst_i,
    // cpu port
    input wire logic [15:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [7:0] rdata_o,
    // mode pins
    input wire logic mode_test_i,
    input wire logic mode_boot_i,
    // download utility
    input wire logic dl_entry_i,
    input wire logic [15:0] dl_entry_addr_i,
    input wire logic [15:0] x_index_i,
    input wire logic [15:0] y_index_i,
    input wire logic [15:0] dl_count_i,
    input wire logic sci_rx_valid_i,
    input wire logic [7:0] sci_rx_data_i,
    input wire logic [7:0] ep_verify_i,
    output logic sci_tx_valid_o,
    output logic [7:0] sci_tx_data_o,
    output logic dl_reset_req_o,
    output logic serial_dl_en_o,
    // program memory array
    output logic ep_latch_arm_o,
    output logic ep_hv_o,
    output logic ep_read_en_o,
    output logic [15:0] ep_prog_addr_o,
    output logic [7:0] ep_prog_data_o,
    output logic ep_extra_col_o,
    output logic ep_extra_row_o,
    // erasable memory array
    output logic ee_latch_arm_o,
    output logic ee_hv_o,
    output logic ee_erase_o,
    output logic [1:0] ee_scope_o,
    output logic ee_read_en_o,
    output logic [15:0] ee_prog_addr_o,
    output logic [7:0] ee_prog_data_o,
    output logic ee_odd_o,
    output logic ee_even_o,
    output logic pump_rc_sel_o
);
    import npc_pkg::*;

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    // test-mode address remap of a captured write
    function automatic logic [15:0] map_addr(input logic [15:0] a, input logic xc, input logic xr,
                                              input logic mb);
        logic [15:0] r;
        r = a;
        if (xc) r = r & XCOL_MASK;
        if (xr) r = r & XROW_MASK;
        if (mb) r = r & MBP_MASK;
        return r;
    endfunction

    // ----------------------------------------
    // mode pin synchronisers
    // ----------------------------------------
    logic test_m_q, test_q, boot_m_q, boot_q;

    // two flops per pin, first read only by second
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            test_m_q <= 1'b0;
            test_q <= 1'b0;
            boot_m_q <= 1'b0;
            boot_q <= 1'b0;
        end else begin
            test_m_q <= mode_test_i;
            test_q <= test_m_q;
            boot_m_q <= mode_boot_i;
            boot_q <= boot_m_q;
        end
    end

    // ----------------------------------------
    // decode
    // ----------------------------------------
    logic ep_lat_q, ep_xcol_q, ep_xrow_q, ep_hv_q;
    logic ee_lat_q, ee_hv_q, ee_erase_q, ee_row_q, ee_byte_q, ee_odd_q, ee_even_q;
    logic ee_target_q, mbp_q, pcs_q;

    wire sel_ep = (addr_i == EP_CTRL_OFS);
    wire sel_ee = (addr_i == EE_CTRL_OFS);
    wire sel_tc = (addr_i == TEST_CTRL_OFS);
    wire wr_ep = wr_i && sel_ep;
    wire wr_ee = wr_i && sel_ee;
    wire wr_tc = wr_i && sel_tc;
    wire ep_array_hit = (addr_i >= EP_FIRST);
    wire ee_array_hit = ((addr_i >= EE_FIRST) && (addr_i <= EE_LAST)) || (addr_i == CONFIG_OFS);
    wire dl_allowed = boot_q || test_q;

    // ----------------------------------------
    // download utility
    // ----------------------------------------
    logic dl_wr, dl_hv, dl_busy;
    logic [15:0] dl_addr;
    logic [7:0] dl_data;
    wire dl_start = dl_entry_i && (dl_entry_addr_i == UTIL_ENTRY) && dl_allowed;

    npc_dl_seq u_dl (
        .clock_i(clock_i),
        .sys_rst_i(sys_rst_i),
        .start_i(dl_start),
        .delay_i(x_index_i),
        .first_addr_i(y_index_i),
        .count_i(dl_count_i),
        .rx_valid_i(sci_rx_valid_i),
        .rx_data_i(sci_rx_data_i),
        .verify_i(ep_verify_i),
        .tx_valid_o(sci_tx_valid_o),
        .tx_data_o(sci_tx_data_o),
        .prog_wr_o(dl_wr),
        .prog_addr_o(dl_addr),
        .prog_data_o(dl_data),
        .hv_o(dl_hv),
        .busy_o(dl_busy),
        .reset_req_o(dl_reset_req_o)
    );

    // ----------------------------------------
    // program memory control
    // ----------------------------------------
    // latch ignores writes while voltage applied; voltage needs latch already set
    wire ep_lat_d = (wr_ep && !ep_hv_q) ? wdata_i[EP_LAT] : ep_lat_q;
    wire ep_hv_d = (wr_ep && ep_lat_q) ? wdata_i[EP_HV] : ep_hv_q;
    wire ep_xcol_d = (wr_ep && test_q) ? wdata_i[EP_XCOL] : ep_xcol_q;
    wire ep_xrow_d = (wr_ep && test_q) ? wdata_i[EP_XROW] : ep_xrow_q;
    wire ep_arm = ep_lat_q || dl_busy;
    wire ep_cap = wr_i && ep_array_hit && ep_lat_q && !ep_hv_q;

    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            ep_lat_q <= CTRL_RST[EP_LAT];
            ep_hv_q <= CTRL_RST[EP_HV];
            ep_xcol_q <= CTRL_RST[EP_XCOL];
            ep_xrow_q <= CTRL_RST[EP_XROW];
        end else begin
            ep_lat_q <= ep_lat_d;
            ep_hv_q <= ep_hv_d;
            ep_xcol_q <= ep_xcol_d;
            ep_xrow_q <= ep_xrow_d;
        end
    end

    // array side of the program memory
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            ep_latch_arm_o <= 1'b0;
            ep_hv_o <= 1'b0;
            ep_read_en_o <= 1'b1;
            ep_prog_addr_o <= 16'h0000;
            ep_prog_data_o <= 8'h00;
            ep_extra_col_o <= 1'b0;
            ep_extra_row_o <= 1'b0;
        end else begin
            ep_latch_arm_o <= ep_arm;
            ep_hv_o <= ep_hv_q || dl_hv;
            ep_read_en_o <= !ep_arm;
            ep_extra_col_o <= ep_xcol_q && test_q;
            ep_extra_row_o <= ep_xrow_q && test_q;
            if (ep_cap) begin
                ep_prog_addr_o <= map_addr(addr_i, ep_xcol_q && test_q, ep_xrow_q && test_q, mbp_q && test_q);
                ep_prog_data_o <= wdata_i;
            end else if (dl_wr) begin
                ep_prog_addr_o <= map_addr(dl_addr, 1'b0, 1'b0, mbp_q && test_q);
                ep_prog_data_o <= dl_data;
            end
        end
    end

    // ----------------------------------------
    // erasable memory control
    // ----------------------------------------
    wire ee_try_both = wdata_i[EE_LAT] && wdata_i[EE_HV];
    // voltage only after arm, target write, then both set
    wire ee_hv_ok = wr_ee && ee_try_both && ee_lat_q && ee_target_q;
    wire ee_lat_d = !wr_ee ? ee_lat_q :
                    (ee_try_both && !ee_lat_q) ? 1'b0 : wdata_i[EE_LAT];
    wire ee_hv_d = !wr_ee ? ee_hv_q : ee_hv_ok;
    wire ee_tgt_hit = wr_i && ee_array_hit && ee_lat_q && !ee_hv_q;
    wire ee_target_d = (wr_ee && !ee_lat_d) ? 1'b0 : (ee_target_q || ee_tgt_hit);

    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            ee_lat_q <= CTRL_RST[EE_LAT];
            ee_hv_q <= CTRL_RST[EE_HV];
            ee_erase_q <= CTRL_RST[EE_ERASE];
            ee_row_q <= CTRL_RST[EE_ROW];
            ee_byte_q <= CTRL_RST[EE_BYTE];
            ee_odd_q <= CTRL_RST[EE_ODD];
            ee_even_q <= CTRL_RST[EE_EVEN];
            ee_target_q <= 1'b0;
        end else begin
            ee_lat_q <= ee_lat_d;
            ee_hv_q <= ee_hv_d;
            ee_target_q <= ee_target_d;
            if (wr_ee) begin
                ee_erase_q <= wdata_i[EE_ERASE];
                ee_row_q <= wdata_i[EE_ROW];
                ee_byte_q <= wdata_i[EE_BYTE];
                ee_odd_q <= wdata_i[EE_ODD] && test_q;
                ee_even_q <= wdata_i[EE_EVEN] && test_q;
            end
        end
    end

    // array side of the erasable memory
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            ee_latch_arm_o <= 1'b0;
            ee_hv_o <= 1'b0;
            ee_erase_o <= 1'b0;
            ee_scope_o <= SCOPE_BULK;
            ee_read_en_o <= 1'b1;
            ee_prog_addr_o <= 16'h0000;
            ee_prog_data_o <= 8'h00;
            ee_odd_o <= 1'b0;
            ee_even_o <= 1'b0;
        end else begin
            ee_latch_arm_o <= ee_lat_q;
            ee_hv_o <= ee_hv_q;
            ee_erase_o <= ee_erase_q;
            ee_scope_o <= ee_byte_q ? SCOPE_BYTE : (ee_row_q ? SCOPE_ROW : SCOPE_BULK);
            ee_read_en_o <= !ee_lat_q;
            ee_odd_o <= ee_odd_q && test_q;
            ee_even_o <= ee_even_q && test_q;
            if (ee_tgt_hit) begin
                ee_prog_addr_o <= addr_i;
                ee_prog_data_o <= wdata_i;
            end
        end
    end

    // ----------------------------------------
    // test control and misc outputs
    // ----------------------------------------
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            mbp_q <= 1'b0;
            pcs_q <= 1'b0;
            pump_rc_sel_o <= 1'b0;
            serial_dl_en_o <= 1'b0;
        end else begin
            if (wr_tc) begin
                mbp_q <= wdata_i[TC_MBP] && test_q;
                pcs_q <= wdata_i[TC_PCS];
            end
            pump_rc_sel_o <= pcs_q;
            serial_dl_en_o <= dl_allowed;
        end
    end

    // ----------------------------------------
    // read path
    // ----------------------------------------
    logic [7:0] ep_view, ee_view, tc_view, rd_mux;
    assign ep_view = {2'b00, ep_lat_q, ep_xcol_q, ep_xrow_q, 2'b00, ep_hv_q};
    assign ee_view = {ee_odd_q, ee_even_q, 1'b0, ee_byte_q, ee_row_q, ee_erase_q, ee_lat_q, ee_hv_q};
    assign tc_view = {6'h00, pcs_q, mbp_q};

    // register select, unmapped reads zero
    always_comb begin
        if (sel_ep) rd_mux = ep_view;
        else if (sel_ee) rd_mux = ee_view;
        else if (sel_tc) rd_mux = tc_view;
        else rd_mux = 8'h00;
    end

    // data stand in the cycle after the strobe only
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) rdata_o <= 8'h00;
        else rdata_o <= rd_i ? rd_mux : 8'h00;
    end

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (sys_rst_i);

    sequence s_ee_arm; ee_lat_q && !ee_hv_q; endsequence
    property p_ep_fixed_zero; rd_i && sel_ep |-> ##1 rdata_o[7:6] == 2'b00 && rdata_o[2:1] == 2'b00; endproperty
    a_ep_fixed_zero: assert property (p_ep_fixed_zero) else $error("reserved bits not zero");
    property p_ep_read_block; ep_lat_q |-> ##1 !ep_read_en_o; endproperty
    a_ep_read_block: assert property (p_ep_read_block) else $error("array read while armed");
    property p_ep_latch_hold; ep_hv_q && wr_ep |=> ep_lat_q == $past(ep_lat_q); endproperty
    a_ep_latch_hold: assert property (p_ep_latch_hold) else $error("latch moved under voltage");
    property p_ep_hv_need; !ep_lat_q && !ep_hv_q && wr_ep |=> !ep_hv_q; endproperty
    a_ep_hv_need: assert property (p_ep_hv_need) else $error("voltage without latch");
    property p_ep_capture; ep_cap |=> ep_prog_data_o == $past(wdata_i); endproperty
    a_ep_capture: assert property (p_ep_capture) else $error("capture lost");
    property p_ee_both; wr_ee && ee_try_both && !ee_lat_q |=> !ee_lat_q && !ee_hv_q; endproperty
    a_ee_both: assert property (p_ee_both) else $error("both bits set at once");
    property p_ee_hv_seq; $rose(ee_hv_q) |-> $past(ee_target_q) ##0 $past(ee_lat_q); endproperty
    a_ee_hv_seq: assert property (p_ee_hv_seq) else $error("voltage out of sequence");
    property p_ee_target; s_ee_arm ##0 ee_tgt_hit |=> ee_target_q; endproperty
    a_ee_target: assert property (p_ee_target) else $error("target write not seen");
    property p_low_volt_inhibit_flag; rd_i && sel_ee |-> ##1 !rdata_o[EE_LOW_VOLT_INHIBIT_FLAG]; endproperty
    a_low_volt_inhibit_flag: assert property (p_low_volt_inhibit_flag) else $error("inhibit status not zero");
    property p_test_gate; !test_q [*2] |-> !ep_extra_col_o && !ee_odd_o && !ee_even_o; endproperty
    a_test_gate: assert property (p_test_gate) else $error("test select outside test mode");
endmodule // npc_top
`default_nettype wire

/* File: rtl/npc_pkg.sv */
// npc_pkg: constants, field positions and types of the nonvolatile program control
// assumes: an 8-bit cpu bus with a 16-bit address and one 10 MHz clock
//
// Operation
// - program control at 0x2b, fields 5,4,3,0
// - latch armed: capture writes, block reads
// - latch write ignored while voltage applied
// - voltage bit written only when latch armed
// - test mode multi-byte: ignore address bit five
// - test mode extra columns: use [11:5]; XCOL_MASK also keeps bit 0 and clears [4:1]
// - test mode extra rows: use [5:0]
// - serial download only bootstrap or test
// - utility at 0xbf00, delay x, start y
// - send 0xff, echo each byte, then reset
// - ee voltage only after arm, target, both
// - setting latch and voltage together clears both
// - ee control always accessible; latch blocks reads
// - pump clock: e clock or rc oscillator
// - inhibit status always reads zero
// - erase scope from byte and row bits
// - erase bit selects erase operation
// - ee voltage bit drives array voltage
// - odd and even bits test mode only
// - ee latch 1, erase 2, byte 4, voltage 0
package npc_pkg;
    localparam logic [15:0] EP_CTRL_OFS = 16'h002b;
    localparam logic [15:0] EE_CTRL_OFS = 16'h003b;
    localparam logic [15:0] TEST_CTRL_OFS = 16'h003e;
    localparam logic [15:0] CONFIG_OFS = 16'h003f;
    localparam logic [15:0] EE_FIRST = 16'h0d80;
    localparam logic [15:0] EE_LAST = 16'h0fff;
    localparam logic [15:0] EP_FIRST = 16'h8000;
    localparam logic [15:0] UTIL_ENTRY = 16'hbf00;
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [7:0] READY_BYTE = 8'hff;
    // program control fields
    localparam int EP_LAT = 5;
    localparam int EP_XCOL = 4;
    localparam int EP_XROW = 3;
    localparam int EP_HV = 0;
    // ee control fields
    localparam int EE_HV = 0;
    localparam int EE_LAT = 1;
    localparam int EE_ERASE = 2;
    localparam int EE_ROW = 3;
    localparam int EE_BYTE = 4;
    localparam int EE_LOW_VOLT_INHIBIT_FLAG = 5;
    localparam int EE_EVEN = 6;
    localparam int EE_ODD = 7;
    // test control fields
    localparam int TC_MBP = 0;
    localparam int TC_PCS = 1;
    // address masks of the test array selects
    localparam logic [15:0] XCOL_MASK = 16'hffe1;
    localparam logic [15:0] XROW_MASK = 16'hf03f;
    localparam logic [15:0] MBP_MASK = 16'hffdf;

    typedef enum logic [1:0] {
        SCOPE_BULK = 2'b00,
        SCOPE_ROW = 2'b01,
        SCOPE_BYTE = 2'b10
    } npc_scope_e;

    typedef enum logic [2:0] {
        DL_IDLE = 3'b000,
        DL_WAIT = 3'b001,
        DL_BURN = 3'b010,
        DL_ECHO = 3'b011,
        DL_DONE = 3'b100
    } npc_dl_e;
endpackage

/* File: rtl/npc_dl_seq.sv */
// npc_dl_seq: serial download sequencer of the resident programming utility
// assumes: byte receive strobes already on clock_i, verify data from the array
`timescale 1ns/100ps
`default_nettype none
module npc_dl_seq (
    // clock and reset
    input wire logic clock_i,
    input wire logic sys_rst_i,
    // start and setup
    input wire logic start_i,
    input wire logic [15:0] delay_i,
    input wire logic [15:0] first_addr_i,
    input wire logic [15:0] count_i,
    // byte exchange
    input wire logic rx_valid_i,
    input wire logic [7:0] rx_data_i,
    input wire logic [7:0] verify_i,
    output logic tx_valid_o,
    output logic [7:0] tx_data_o,
    // programming requests
    output logic prog_wr_o,
    output logic [15:0] prog_addr_o,
    output logic [7:0] prog_data_o,
    output logic hv_o,
    output logic busy_o,
    output logic reset_req_o
);
    import npc_pkg::*;

    npc_dl_e state_q;
    logic [15:0] cnt_q;
    logic [15:0] left_q;

    // ----------------------------------------
    // sequencer
    // ----------------------------------------
    always_ff @(posedge clock_i) begin
        tx_valid_o <= 1'b0;
        prog_wr_o <= 1'b0;
        reset_req_o <= 1'b0;
        if (sys_rst_i) begin
            state_q <= DL_IDLE;
            cnt_q <= 16'h0000;
            left_q <= 16'h0000;
            tx_data_o <= 8'h00;
            prog_addr_o <= 16'h0000;
            prog_data_o <= 8'h00;
            hv_o <= 1'b0;
            busy_o <= 1'b0;
        end else begin
            case (state_q)
                DL_IDLE: begin
                    if (start_i) begin
                        tx_valid_o <= 1'b1;
                        tx_data_o <= READY_BYTE;
                        prog_addr_o <= first_addr_i;
                        left_q <= count_i;
                        busy_o <= 1'b1;
                        state_q <= DL_WAIT;
                    end
                end
                DL_WAIT: begin
                    if (rx_valid_i) begin
                        prog_wr_o <= 1'b1;
                        prog_data_o <= rx_data_i;
                        cnt_q <= delay_i;
                        state_q <= DL_BURN;
                    end
                end
                DL_BURN: begin
                    hv_o <= (cnt_q != 16'h0000);
                    if (cnt_q == 16'h0000) begin
                        state_q <= DL_ECHO;
                    end else begin
                        cnt_q <= cnt_q - 16'h0001;
                    end
                end
                DL_ECHO: begin
                    tx_valid_o <= 1'b1;
                    tx_data_o <= verify_i;
                    prog_addr_o <= prog_addr_o + 16'h0001;
                    left_q <= left_q - 16'h0001;
                    state_q <= (left_q <= 16'h0001) ? DL_DONE : DL_WAIT;
                end
                default: begin
                    reset_req_o <= 1'b1;
                    busy_o <= 1'b0;
                    state_q <= DL_IDLE;
                end
            endcase
        end
    end
endmodule // npc_dl_seq
`default_nettype wire

/* File: dv/npc_host_model.sv */
// npc_host_model: serial host and array read-back beside the programming control
// assumes: byte strobes on clock_i, echo bytes follow the 0xff ready byte
`timescale 1ns/100ps
`default_nettype none
module npc_host_model
    import npc_pkg::*;
#(
    parameter int GAP = 3
) (
    // clock
    input wire logic clock_i,
    // bytes from the device
    input wire logic tx_valid_i,
    input wire logic [7:0] tx_data_i,
    // byte latched for programming
    input wire logic [7:0] prog_data_i,
    // bytes towards the device
    output logic rx_valid_o,
    output logic [7:0] rx_data_o,
    output logic [7:0] verify_o
);
    logic [7:0] bytes_q [0:1];
    logic [7:0] echo_q [0:1];
    int n_sent = 0;
    int n_echo = 0;
    int n_ff = 0;
    int gap_q = 0;
    initial begin
        bytes_q[0] = 8'h3c;
        bytes_q[1] = 8'hc3;
        rx_valid_o = 1'b0;
        rx_data_o = 8'h00;
    end
    // array reads back the byte just programmed
    assign verify_o = prog_data_i;
    // send next byte a few cycles after each device byte
    always @(posedge clock_i) begin
        rx_valid_o <= 1'b0;
        rx_data_o <= ~rx_data_o; // no stale byte between sends
        if (gap_q == 1 && n_sent < 2) begin
            rx_valid_o <= 1'b1;
            rx_data_o <= bytes_q[n_sent];
            n_sent <= n_sent + 1;
        end
        if (gap_q > 0)
            gap_q <= gap_q - 1;
        if (tx_valid_i === 1'b1) begin
            gap_q <= GAP;
            if (tx_data_i === READY_BYTE)
                n_ff <= n_ff + 1;
            else if (n_echo < 2) begin
                echo_q[n_echo] <= tx_data_i;
                n_echo <= n_echo + 1;
            end
        end
    end
endmodule // npc_host_model
`default_nettype wire

/* File: dv/tb_top.sv */
// tb_top: register and download tests of the programming control
// assumes: npc_top on a 10 MHz clock, host model on its serial side
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    import npc_pkg::*;
    // ----------------------------------------
    // signals
    // ----------------------------------------
    logic clock_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic [15:0] addr_i = 16'h0000;
    logic [7:0] wdata_i = 8'h00;
    logic wr_i = 1'b0, rd_i = 1'b0, mode_test_i = 1'b0, mode_boot_i = 1'b0, dl_entry_i = 1'b0;
    logic [15:0] dl_entry_addr_i = UTIL_ENTRY, x_index_i = 16'h0004, y_index_i = EP_FIRST, dl_count_i = 16'h0002;
    logic [7:0] rdata_o, sci_tx_data_o, ep_prog_data_o, ee_prog_data_o, verify, rx_data;
    logic sci_tx_valid_o, dl_reset_req_o, serial_dl_en_o, ep_latch_arm_o, ep_hv_o, ep_read_en_o, rx_valid;
    logic ep_extra_col_o, ep_extra_row_o, ee_latch_arm_o, ee_hv_o, ee_erase_o, ee_read_en_o;
    logic ee_odd_o, ee_even_o, pump_rc_sel_o;
    logic [15:0] ep_prog_addr_o, ee_prog_addr_o;
    logic [1:0] ee_scope_o;
    int fails = 0, compares = 0, cyc = 0, hv_cyc = 0, h0;

    always #50 clock_i = ~clock_i;

    npc_top uut (.clock_i, .sys_rst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .mode_test_i, .mode_boot_i,
        .dl_entry_i, .dl_entry_addr_i, .x_index_i, .y_index_i, .dl_count_i, .sci_rx_valid_i(rx_valid),
        .sci_rx_data_i(rx_data), .ep_verify_i(verify), .sci_tx_valid_o, .sci_tx_data_o, .dl_reset_req_o,
        .serial_dl_en_o, .ep_latch_arm_o, .ep_hv_o, .ep_read_en_o, .ep_prog_addr_o, .ep_prog_data_o,
        .ep_extra_col_o, .ep_extra_row_o, .ee_latch_arm_o, .ee_hv_o, .ee_erase_o, .ee_scope_o, .ee_read_en_o,
        .ee_prog_addr_o, .ee_prog_data_o, .ee_odd_o, .ee_even_o, .pump_rc_sel_o);

    npc_host_model host (.clock_i(clock_i), .tx_valid_i(sci_tx_valid_o), .tx_data_i(sci_tx_data_o),
        .prog_data_i(ep_prog_data_o), .rx_valid_o(rx_valid), .rx_data_o(rx_data), .verify_o(verify));

    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clock_i);
        wr_i <= 1'b1;
        addr_i <= a;
        wdata_i <= d;
        @(posedge clock_i);
        wr_i <= 1'b0;
    endtask
    task automatic rdchk(input string nm, input logic [15:0] a, input logic [7:0] exp);
        @(posedge clock_i);
        rd_i <= 1'b1;
        addr_i <= a;
        @(posedge clock_i);
        rd_i <= 1'b0;
        #1;
        chk(nm, rdata_o, exp);
    endtask
    task automatic settle;
        repeat (2) @(posedge clock_i);
        #1;
    endtask
    task automatic pulse_entry(input logic [15:0] a);
        @(posedge clock_i);
        dl_entry_addr_i <= a;
        dl_entry_i <= 1'b1;
        @(posedge clock_i);
        dl_entry_i <= 1'b0;
    endtask
    task automatic tally_and_finish;
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // cycle ceiling and voltage-on count
    always @(posedge clock_i) begin
        cyc <= cyc + 1;
        if (ep_hv_o === 1'b1)
            hv_cyc <= hv_cyc + 1;
        if (cyc == 20000) begin
            fails++;
            tally_and_finish();
        end
    end

    // ----------------------------------------
    // test sequence
    // ----------------------------------------
    initial begin
        repeat (6) @(posedge clock_i);
        sys_rst_i <= 1'b0;
        settle;
        chk("ep read en", ep_read_en_o, 1'b1);
        rdchk("ep ctrl reset", EP_CTRL_OFS, CTRL_RST);
        rdchk("ee ctrl reset", EE_CTRL_OFS, CTRL_RST);
        rdchk("unmapped", 16'h0010, 8'h00);
        wr(EP_CTRL_OFS, 8'h01);
        rdchk("hv no latch", EP_CTRL_OFS, 8'h00);
        wr(EP_CTRL_OFS, 8'h20);
        wr(16'h8123, 8'h5a);
        wr(16'h8456, 8'ha5);
        settle;
        chk("ep read blocked", ep_read_en_o, 1'b0);
        chk("ep latch arm", ep_latch_arm_o, 1'b1);
        chk("ep addr", ep_prog_addr_o, 16'h8456);
        chk("ep data", ep_prog_data_o, 8'ha5);
        wr(EP_CTRL_OFS, 8'h21);
        settle;
        chk("ep hv", ep_hv_o, 1'b1);
        wr(EP_CTRL_OFS, 8'h01);
        rdchk("latch held", EP_CTRL_OFS, 8'h21);
        wr(EP_CTRL_OFS, 8'h00);
        rdchk("latch held hv off", EP_CTRL_OFS, 8'h20);
        wr(EP_CTRL_OFS, 8'h00);
        wr(16'h8777, 8'h33);
        settle;
        chk("ep hv off", ep_hv_o, 1'b0);
        chk("no capture unarmed", ep_prog_addr_o, 16'h8456);
        wr(EP_CTRL_OFS, 8'hb8);
        rdchk("test bits refused", EP_CTRL_OFS, 8'h20);
        wr(EP_CTRL_OFS, 8'h00);
        $display("test program memory done");
        wr(EE_CTRL_OFS, 8'h03);
        rdchk("ee both at once", EE_CTRL_OFS, 8'h00);
        wr(EE_CTRL_OFS, 8'h02);
        wr(EE_CTRL_OFS, 8'h03);
        settle;
        chk("ee hv no target", ee_hv_o, 1'b0);
        wr(EE_CTRL_OFS, 8'h00);
        wr(EE_CTRL_OFS, 8'h02);
        wr(EE_FIRST, 8'h11);
        wr(EE_CTRL_OFS, 8'h03);
        settle;
        chk("ee hv", ee_hv_o, 1'b1);
        chk("ee addr", ee_prog_addr_o, EE_FIRST);
        chk("ee read blocked", ee_read_en_o, 1'b0);
        chk("ee latch arm", ee_latch_arm_o, 1'b1);
        chk("ee data", ee_prog_data_o, 8'h11);
        wr(EE_CTRL_OFS, 8'h00);
        settle;
        chk("ee hv off", ee_hv_o, 1'b0);
        chk("ee read en", ee_read_en_o, 1'b1);
        for (int i = 0; i < 4; i++) begin
            wr(EE_CTRL_OFS, {3'b000, i[1:0], 3'b110});
            settle;
            chk("ee erase", ee_erase_o, 1'b1);
            chk("ee scope", ee_scope_o, i[1] ? 2'b10 : {1'b0, i[0]});
        end
        wr(EE_CTRL_OFS, 8'he2);
        rdchk("ee odd even inhibit", EE_CTRL_OFS, 8'h02);
        chk("ee odd off", ee_odd_o, 1'b0);
        chk("ee erase off", ee_erase_o, 1'b0);
        wr(EE_CTRL_OFS, 8'h00);
        wr(TEST_CTRL_OFS, 8'h02);
        settle;
        chk("pump rc", pump_rc_sel_o, 1'b1);
        wr(TEST_CTRL_OFS, 8'h00);
        settle;
        chk("pump e clock", pump_rc_sel_o, 1'b0);
        $display("test erasable memory done");
        @(posedge clock_i);
        mode_test_i <= 1'b1;
        repeat (4) @(posedge clock_i);
        wr(TEST_CTRL_OFS, 8'h01);
        wr(EP_CTRL_OFS, 8'h20);
        wr(16'h8025, 8'h77);
        settle;
        chk("multi byte addr", ep_prog_addr_o, 16'h8025 & MBP_MASK);
        wr(TEST_CTRL_OFS, 8'h00);
        wr(EP_CTRL_OFS, 8'h30);
        wr(16'h8fff, 8'h81);
        settle;
        chk("extra col", ep_extra_col_o, 1'b1);
        chk("extra col addr", ep_prog_addr_o, 16'h8fff & XCOL_MASK);
        wr(EP_CTRL_OFS, 8'h28);
        wr(16'h8fff, 8'h18);
        settle;
        chk("extra row", ep_extra_row_o, 1'b1);
        chk("extra row addr", ep_prog_addr_o, 16'h8fff & XROW_MASK);
        wr(EE_CTRL_OFS, 8'hc0);
        settle;
        chk("ee odd", ee_odd_o, 1'b1);
        chk("ee even", ee_even_o, 1'b1);
        wr(EE_CTRL_OFS, 8'h00);
        wr(EP_CTRL_OFS, 8'h00);
        mode_test_i <= 1'b0;
        // let the mode synchroniser drop before the entry pulse
        repeat (4) @(posedge clock_i);
        $display("test test mode done");
        pulse_entry(UTIL_ENTRY);
        repeat (30) @(posedge clock_i);
        chk("no utility normal", host.n_ff, 0);
        mode_boot_i <= 1'b1;
        repeat (4) @(posedge clock_i);
        pulse_entry(16'hbf01);
        repeat (30) @(posedge clock_i);
        chk("no utility wrong entry", host.n_ff, 0);
        chk("serial enable", serial_dl_en_o, 1'b1);
        h0 = hv_cyc;
        pulse_entry(UTIL_ENTRY);
        for (int k = 0; k < 500; k++) begin
            @(posedge clock_i);
            #1;
            if (dl_reset_req_o === 1'b1)
                break;
        end
        chk("reset request", dl_reset_req_o, 1'b1);
        chk("ready bytes", host.n_ff, 1);
        chk("echo count", host.n_echo, 2);
        chk("echo 0", host.echo_q[0], 8'h3c);
        chk("echo 1", host.echo_q[1], 8'hc3);
        chk("last addr", ep_prog_addr_o, y_index_i + 16'h0001);
        chk("delay from x", (hv_cyc - h0 >= 8 && hv_cyc - h0 <= 10), 1'b1);
        $display("test download done");
        tally_and_finish();
    end
endmodule // tb_top
`default_nettype wire
